/* File: core/charge_pkg.sv */
// Shared constants for the battery charge indicator
package charge_pkg;
    localparam int VOLT_W       = 16;
    localparam int CELL_VOLT_W  = 12;
    localparam int PCT_W        = 7;
    localparam logic [6:0] PCT_FULL   = 7'h64;
    localparam logic [6:0] PCT_EMPTY  = 7'h00;
    localparam int CELL_DIVISOR = 2;
    localparam int PCT_DIVISOR  = 100;
    localparam int CLK_HZ       = 20000000;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = (CLK_HZ / 1000000) * TICK_US;
    localparam int MINUTE_TICKS = 60000;
    localparam logic [9:0] DRAIN_MAX  = 10'h258;
    localparam logic [7:0] UV_RAW_MIN = 8'h80;
    localparam logic [7:0] UV_RAW_MAX = 8'hCC;
    localparam int UV_SCALE_SHIFT = 8;
endpackage

/* File: core/level_if.sv */
// Voltage level bundle between the indicator and its level calculator
`timescale 1ns/100ps
interface level_if;
    logic [15:0] resetLevel;
    logic [15:0] fullLevel;
    logic [15:0] emptyLevel;
    logic [15:0] socLevel;
    modport calc (output resetLevel, fullLevel, emptyLevel, socLevel);
    modport user (input resetLevel, fullLevel, emptyLevel, socLevel);
endinterface

/* File: core/level_calc.sv */
// Voltage level calculator from per-cell settings and cell count
`timescale 1ns/100ps
module level_calc
(
    // Settings
    input  wire logic [11:0] resetCellVolts,
    input  wire logic [11:0] fullCellVolts,
    input  wire logic [11:0] emptyCellVolts,
    input  wire logic [7:0]  cellCount,
    input  wire logic [6:0]  chargePercent,
    // Levels
    level_if.calc            lv
);
    function automatic logic [15:0] cellMul(input logic [11:0] v, input logic [7:0] n);
        logic [19:0] p;
        p = 20'(v) * 20'(n);
        cellMul = (p > 20'h0FFFF) ? 16'hFFFF : p[15:0];
    endfunction

    logic [15:0] spanLevel;
    logic [23:0] scaled;
    logic [15:0] socOffset;

    assign lv.resetLevel = cellMul(resetCellVolts, cellCount); // RULE_04
    assign lv.fullLevel  = cellMul(fullCellVolts, cellCount);  // RULE_06
    assign lv.emptyLevel = cellMul(emptyCellVolts, cellCount); // RULE_07
    assign spanLevel = (lv.fullLevel > lv.emptyLevel) ? (lv.fullLevel - lv.emptyLevel) : 16'h0000;
    assign scaled    = 24'(spanLevel) * 24'(chargePercent);
    assign socOffset = 16'(scaled / 24'(charge_pkg::PCT_DIVISOR));
    assign lv.socLevel = lv.emptyLevel + socOffset; // RULE_08
endmodule

/* File: core/battery_charge_indicator.sv */
// Battery state-of-charge estimator with undervoltage threshold
//
// Contract
// RULE_01: Recompute percentage while keyswitch is on
// RULE_02: Save percentage to storage at key-off
// RULE_03: Key-on reset to full checked once
// RULE_04: Reset level is reset per-cell times cells
// RULE_05: Cell count is nominal voltage halved
// RULE_06: Full level is full per-cell times cells
// RULE_07: Empty level is empty per-cell times cells
// RULE_08: Threshold is empty plus scaled span
// RULE_09: Accumulate time voltage is below threshold
// RULE_10: Past limit, drop one point and recompute
// RULE_11: Drain minutes set full-to-empty time
// RULE_12: Reset per-cell must exceed full per-cell
// RULE_13: Reset suppressed at or above inhibit percent
// RULE_14: Undervoltage setting is percent of nominal
// RULE_15: Cut drive current at undervoltage
// RULE_16: Threshold never below power stage minimum
// RULE_17: Standard per-cell values recommended
// RULE_18: Clear time after decrement, hold at zero
`timescale 1ns/100ps
module battery_charge_indicator
#(
    parameter int TICK_CYCLES = charge_pkg::TICK_CYCLES,
    parameter logic [15:0] STAGE_MIN_VOLTS = 16'h0000
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    // Keyswitch and voltage
    input  wire logic        keyswitchInput,
    input  wire logic [15:0] filteredVolts,
    input  wire logic [15:0] nominalVolts,
    // Settings
    input  wire logic [11:0] resetCellVolts,
    input  wire logic [11:0] fullCellVolts,
    input  wire logic [11:0] emptyCellVolts,
    input  wire logic [9:0]  drainMinutes,
    input  wire logic [6:0]  resetInhibitPct,
    input  wire logic [7:0]  userUndervoltRaw,
    // Nonvolatile storage
    input  wire logic [6:0]  storedPercent,
    output logic      [6:0]  saveData,
    output logic             saveStrobe,
    // Status
    output logic      [6:0]  chargePercent,
    output logic      [15:0] undervoltLevel,
    output logic             driveCutback
);
    // ************************************
    // Keyswitch synchroniser
    // ************************************
    // Only the second and third flops feed logic
    logic keySync1_q;
    logic keySync2_q;
    logic keyPrev_q;
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            keySync1_q <= 1'b0;
            keySync2_q <= 1'b0;
            keyPrev_q  <= 1'b0;
        end
        else if (clkEn)
        begin
            keySync1_q <= keyswitchInput;
            keySync2_q <= keySync1_q;
            keyPrev_q  <= keySync2_q;
        end
    end
    wire keyOn   = keySync2_q;
    // Key already on at power-up counts as key-on
    wire keyRise = keySync2_q & ~keyPrev_q;
    wire keyFall = ~keySync2_q & keyPrev_q;

    // ************************************
    // Voltage sample registers
    // ************************************
    // Delayed like the keyswitch so key-on sees settled volts
    logic [15:0] voltsS1_q;
    logic [15:0] voltsS2_q;
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            voltsS1_q <= 16'h0000;
            voltsS2_q <= 16'h0000;
        end
        else if (clkEn)
        begin
            voltsS1_q <= filteredVolts;
            voltsS2_q <= voltsS1_q;
        end
    end

    // ************************************
    // Levels
    // ************************************
    logic [6:0] pct_q;
    logic [6:0] pct_d;
    wire  [7:0] cellCount = nominalVolts[8:1]; // RULE_05
    level_if lv ();
    level_calc u_levels
    (
        .resetCellVolts (resetCellVolts),
        .fullCellVolts  (fullCellVolts),
        .emptyCellVolts (emptyCellVolts),
        .cellCount      (cellCount),
        .chargePercent  (pct_q),
        .lv             (lv.calc)
    );

    // ************************************
    // Discharge timing
    // ************************************
    logic [15:0] tick_q;
    logic [31:0] below_q;
    logic [31:0] below_d;
    wire         tickHit  = (tick_q == 16'(TICK_CYCLES - 1));
    wire         isBelow  = voltsS2_q < lv.socLevel;
    // Limit in ticks: minutes*60000 ms / 100 per point
    wire  [31:0] limitTicks = 32'(drainMinutes)
                            * 32'(charge_pkg::MINUTE_TICKS / charge_pkg::PCT_DIVISOR); // RULE_11
    wire         limitHit = below_q > limitTicks; // RULE_10
    wire         resetOk  = (voltsS2_q > lv.resetLevel) && (storedPercent < resetInhibitPct); // RULE_13

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            tick_q <= 16'h0000;
        // Idles while the key is off
        else if (clkEn)
            tick_q <= (tickHit || !keyOn) ? 16'h0000 : tick_q + 16'h0001;
    end

    always_comb
    begin
        pct_d   = pct_q;
        below_d = below_q;
        // Key-on takes priority over counting
        if (keyRise)
        begin
            pct_d   = resetOk ? charge_pkg::PCT_FULL : storedPercent; // RULE_03
            below_d = 32'h0000_0000;
        end
        else if (keyOn)
        begin
            if (limitHit)
            begin
                below_d = 32'h0000_0000; // RULE_18
                // Sticks at zero instead of wrapping
                if (pct_q != charge_pkg::PCT_EMPTY)
                    pct_d = pct_q - 7'h01; // RULE_10
            end
            else if (tickHit && isBelow)
                below_d = below_q + 32'h0000_0001; // RULE_09
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pct_q   <= charge_pkg::PCT_FULL;
            below_q <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            pct_q   <= pct_d; // RULE_01
            below_q <= below_d;
        end
    end

    // ************************************
    // Nonvolatile save
    // ************************************
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            saveData   <= 7'h00;
            saveStrobe <= 1'b0;
        end
        else if (clkEn)
        begin
            // One-cycle strobe; data stands until next key-off
            saveStrobe <= keyFall; // RULE_02
            if (keyFall)
                saveData <= pct_q;
        end
    end

    // ************************************
    // Undervoltage threshold
    // ************************************
    wire [7:0]  uvClamped = (userUndervoltRaw < charge_pkg::UV_RAW_MIN) ? charge_pkg::UV_RAW_MIN :
                            (userUndervoltRaw > charge_pkg::UV_RAW_MAX) ? charge_pkg::UV_RAW_MAX :
                            userUndervoltRaw;
    wire [23:0] uvProduct = 24'(nominalVolts) * 24'(uvClamped); // RULE_14
    wire [15:0] uvUser    = uvProduct[23:8];
    wire [15:0] uvLevel   = (uvUser < STAGE_MIN_VOLTS) ? STAGE_MIN_VOLTS : uvUser; // RULE_16
    wire        underVolt = (voltsS2_q <= uvLevel); // RULE_15
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            undervoltLevel <= 16'h0000;
            driveCutback   <= 1'b0;
        end
        else if (clkEn)
        begin
            undervoltLevel <= uvLevel;
            driveCutback   <= underVolt; // RULE_15
        end
    end

    assign chargePercent = pct_q;
endmodule

/* File: verification/pack_model.sv */
// Nonvolatile store and per-cell settings of the battery side
`timescale 1ns/100ps
module pack_model
#(
    parameter bit SEALED = 1'b0
)
(
    input  wire logic       core_clk,
    input  wire logic       presetEn,
    input  wire logic [6:0] preset,
    input  wire logic       saveStrobe,
    input  wire logic [6:0] saveData,
    output logic      [11:0] resetCellVolts,
    output logic      [11:0] fullCellVolts,
    output logic      [11:0] emptyCellVolts,
    output logic      [6:0]  storedPercent
);
    assign resetCellVolts = 12'h82A;
    assign fullCellVolts  = 12'h7F8;
    assign emptyCellVolts = SEALED ? 12'h76C : 12'h6C2;
    always_ff @(posedge core_clk)
        if (presetEn)
            storedPercent <= preset;
        else if (saveStrobe)
            storedPercent <= saveData;
endmodule

/* File: verification/battery_charge_indicator_checker.sv */
// Port assertions for the charge indicator
`timescale 1ns/100ps
module battery_charge_indicator_checker
#(
    parameter logic [15:0] STAGE_MIN_VOLTS = 16'h0000
)
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        clkEn,
    input wire logic        keyswitchInput,
    input wire logic [15:0] filteredVolts,
    input wire logic [15:0] nominalVolts,
    input wire logic [11:0] resetCellVolts,
    input wire logic [9:0]  drainMinutes,
    input wire logic [6:0]  resetInhibitPct,
    input wire logic [7:0]  userUndervoltRaw,
    input wire logic [6:0]  storedPercent,
    input wire logic [6:0]  saveData,
    input wire logic        saveStrobe,
    input wire logic [6:0]  chargePercent,
    input wire logic [15:0] undervoltLevel,
    input wire logic        driveCutback
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn || !clkEn);
    wire [7:0]  rawLo = userUndervoltRaw < 8'h80 ? 8'h80 : userUndervoltRaw;
    wire [7:0]  rawC = rawLo > 8'hCC ? 8'hCC : rawLo;
    wire [23:0] uvProd = 24'(nominalVolts) * 24'(rawC);
    wire [15:0] uvExp = uvProd[23:8] < STAGE_MIN_VOLTS ? STAGE_MIN_VOLTS : uvProd[23:8];
    wire [23:0] rstLvl = 24'(resetCellVolts) * 24'(nominalVolts[8:1]);
    wire        doFull = filteredVolts > rstLvl && storedPercent < resetInhibitPct;
    wire [6:0]  onExp = doFull ? 7'h64 : storedPercent;
    a_keyon_load: assert property ($rose(keyswitchInput) |-> ##5 chargePercent == onExp)
        else $error("key-on percent");
    a_save_pulse: assert property ($fell(keyswitchInput) |-> ##[2:5] saveStrobe)
        else $error("no save");
    a_save_value: assert property (saveStrobe |-> saveData == chargePercent ##1 !saveStrobe)
        else $error("save value");
    a_pct_step: assert property (keyswitchInput[*8] ##1 $changed(chargePercent) |->
        chargePercent == $past(chargePercent) - 7'h01) else $error("step");
    a_idle_hold: assert property ((!keyswitchInput)[*5] |=> $stable(chargePercent))
        else $error("count while off");
    a_drain_fast: assert property ((keyswitchInput && drainMinutes == 10'h000 &&
        filteredVolts == 16'h0000 && chargePercent != 7'h00)[*8] |-> ##[0:16] $changed(chargePercent))
        else $error("no drain");
    a_uv_level: assert property (($stable(nominalVolts) && $stable(userUndervoltRaw))[*4] |->
        undervoltLevel == uvExp) else $error("uv level");
    a_cutback: assert property (($stable(filteredVolts) && $stable(undervoltLevel))[*4] |->
        driveCutback == (filteredVolts <= undervoltLevel)) else $error("cutback");
endmodule
bind battery_charge_indicator battery_charge_indicator_checker
    #(.STAGE_MIN_VOLTS(STAGE_MIN_VOLTS)) chk
(
    .core_clk         (core_clk),
    .rstn             (rstn),
    .clkEn            (clkEn),
    .keyswitchInput   (keyswitchInput),
    .filteredVolts    (filteredVolts),
    .nominalVolts     (nominalVolts),
    .resetCellVolts   (resetCellVolts),
    .drainMinutes     (drainMinutes),
    .resetInhibitPct  (resetInhibitPct),
    .userUndervoltRaw (userUndervoltRaw),
    .storedPercent    (storedPercent),
    .saveData         (saveData),
    .saveStrobe       (saveStrobe),
    .chargePercent    (chargePercent),
    .undervoltLevel   (undervoltLevel),
    .driveCutback     (driveCutback)
);

/* File: verification/battery_charge_indicator_bench.sv */
// Self-checking bench for the charge indicator
`timescale 1ns/100ps
module battery_charge_indicator_bench;
    typedef struct packed
    {
        logic [15:0] v; logic [6:0] st; logic [6:0] inh; logic [7:0] raw; logic [6:0] pct; logic [15:0] uv;
    } row_s;
    row_s rows[4] = '{'{16'hC418, 7'h28, 7'h5A, 8'h80, 7'h64, 16'h001E},
        '{16'hC418, 7'h5F, 7'h5A, 8'h64, 7'h5F, 16'h001E},
        '{16'hC3F0, 7'h28, 7'h5A, 8'hCC, 7'h28, 16'h0026},
        '{16'hC418, 7'h5A, 7'h5A, 8'hFF, 7'h5A, 16'h0026}};
    logic core_clk = 0, rstn = 0, keyswitchInput = 0, presetEn = 0, clkEn = 1;
    logic [15:0] filteredVolts = 16'hC418, nominalVolts = 16'h0030;
    logic [9:0]  drainMinutes = 10'h001;
    logic [6:0]  resetInhibitPct = 7'h5A, preset = 7'h28;
    logic [7:0]  userUndervoltRaw = 8'h80;
    wire         saveStrobe, driveCutback;
    wire [15:0]  undervoltLevel;
    wire [11:0]  resetCellVolts, fullCellVolts, emptyCellVolts;
    wire [6:0]   storedPercent, saveData, chargePercent;
    int miscompares = 0, num_checks = 0, cycles = 0, saves = 0, n, t0;
    pack_model PM (.*);
    battery_charge_indicator #(.TICK_CYCLES(4), .STAGE_MIN_VOLTS(16'h001E)) DUT
        (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic key(input logic on, input logic [6:0] st);
        preset = st;
        presetEn = !on;
        @(negedge core_clk);
        presetEn = 0;
        n = saves;
        keyswitchInput = on;
        repeat (8) @(negedge core_clk);
    endtask
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        saves += (saveStrobe === 1'b1);
        if (cycles == 12000)
        begin
            miscompares++;
            stop_test();
        end
    end
    initial
    begin
        repeat (2) @(negedge core_clk);
        rstn = 1;
        check(chargePercent, 7'h64);
        foreach (rows[i])
        begin
            filteredVolts = rows[i].v;
            resetInhibitPct = rows[i].inh;
            userUndervoltRaw = rows[i].raw;
            key(0, rows[i].st);
            key(1, rows[i].st);
            check(chargePercent, rows[i].pct);
            check(undervoltLevel, rows[i].uv);
            check(driveCutback, 1'b0);
            key(0, 7'h00);
            check(16'(saves - n), 16'h0001);
            check(storedPercent, rows[i].pct);
        end
        drainMinutes = 10'h000;
        resetInhibitPct = 7'h00;
        key(0, 7'h03);
        key(1, 7'h03);
        check(chargePercent, 7'h03);
        filteredVolts = 16'h0000;
        clkEn = 0;
        repeat (20) @(negedge core_clk);
        check(chargePercent, 7'h03);
        check(driveCutback, 1'b0);
        clkEn = 1;
        repeat (100) @(negedge core_clk);
        check(chargePercent, 7'h00);
        check(driveCutback, 1'b1);
        key(0, 7'h05);
        check(storedPercent, 7'h00);
        drainMinutes = 10'h001;
        resetInhibitPct = 7'h5A;
        filteredVolts = 16'hA230;
        key(0, 7'h32);
        key(1, 7'h32);
        while (chargePercent === 7'h32 && cycles < 9000) @(negedge core_clk);
        t0 = cycles;
        while (chargePercent === 7'h31 && cycles < 9000) @(negedge core_clk);
        check(16'(cycles - t0 > 2399 && cycles - t0 < 2411), 16'h0001);
        check(chargePercent, 7'h30);
        rstn = 0;
        repeat (2) @(negedge core_clk);
        check(chargePercent, 7'h64);
        check(saveStrobe, 1'b0);
        rstn = 1;
        repeat (4) @(negedge core_clk);
        check(chargePercent, 7'h32);
        nominalVolts = 16'h0040;
        repeat (2) @(negedge core_clk);
        check(undervoltLevel, 16'h0033);
        stop_test();
    end
endmodule
